// File: adc_frame_pkg.sv
// Shared types and constants for the serial converter frame logic
package adc_frame_pkg;

	localparam int RESULT_W = 12;
	localparam int EDGE_W   = 5;

	typedef logic [RESULT_W-1:0] code_t;
	typedef logic [EDGE_W-1:0]   edge_cnt_t;

	// Falling-edge numbers within one frame
	localparam edge_cnt_t HOLD_EDGE         = 5'h03;
	localparam edge_cnt_t FIRST_RESULT_EDGE = 5'h04;
	localparam edge_cnt_t LAST_RESULT_EDGE  = 5'h0F;
	localparam edge_cnt_t LAST_EDGE         = 5'h10;
	localparam edge_cnt_t EDGE_ONE          = 5'h01;
	localparam edge_cnt_t EDGE_NONE         = 5'h00;

	localparam code_t CODE_ZERO = 12'h000;
	localparam code_t TRIAL_MSB = 12'h800;
	localparam logic  LEAD_BIT  = 1'h0;

	// Idle pin levels used as synchroniser reset values
	localparam logic CS_IDLE   = 1'h1;
	localparam logic SCLK_IDLE = 1'h0;

	typedef enum logic [1:0] {
		ST_SHUTDOWN,
		ST_TRACK,
		ST_CONVERT,
		ST_DONE
	} frame_state_t;

	typedef struct packed {
		logic cs_n;
		logic sclk;
	} link_in_t;

	typedef struct packed {
		logic data;
		logic oe;
	} serial_pin_t;

	typedef struct packed {
		logic shutdown;
		logic tracking;
		logic converting;
	} frame_status_t;

	typedef struct packed {
		frame_state_t st;
		edge_cnt_t    edges;
		logic         sclk_prev;
		serial_pin_t  pin;
		code_t        code;
		logic         code_valid;
		logic         first_seen;
		logic         untrusted;
	} frame_regs_t;

	localparam frame_regs_t FRAME_REGS_RST = '{
		st: ST_SHUTDOWN, edges: EDGE_NONE, sclk_prev: SCLK_IDLE,
		pin: '{data: LEAD_BIT, oe: 1'h0}, code: CODE_ZERO,
		code_valid: 1'h0, first_seen: 1'h0, untrusted: 1'h1
	};

endpackage

// File: pin_sync.sv
// Two-flop synchroniser for pins from outside the system clock domain
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
	parameter int         W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         sys_clk,  // System clock
	input  wire logic         resetn,   // Async reset, active low
	input  wire logic [W-1:0] async_in, // Raw pin level
	output logic      [W-1:0] sync_out  // Level after two flops
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} sync_regs_t;

	sync_regs_t q;
	sync_regs_t d;

	always_comb begin
		d.meta   = async_in;
		d.stable = q.meta;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			q <= '{meta: RST, stable: RST};
		end else begin
			q <= d;
		end
	end

	assign sync_out = q.stable;
endmodule
`default_nettype wire

// File: sar_engine.sv
// Successive-approximation engine: tracks, holds and resolves one bit per step
`timescale 1ns/1ns
`default_nettype none
module sar_engine
	import adc_frame_pkg::*;
(
	input  wire logic                 sys_clk,     // System clock
	input  wire logic                 resetn,      // Async reset, active low
	input  wire logic                 track,       // Follow the input sample
	input  wire logic                 decide,      // Resolve the next bit
	input  wire adc_frame_pkg::code_t sample,      // Digitised input level
	output logic                      decided_bit, // Bit resolved by this step
	output adc_frame_pkg::code_t      held_code,   // Held sample
	output adc_frame_pkg::code_t      result       // Bits resolved so far
);
	typedef struct packed {
		code_t held;
		code_t approx;
		code_t mask;
	} sar_regs_t;

	sar_regs_t q;
	sar_regs_t d;

	// Comparator: is the held level at or above the trial code
	function automatic logic trial_ge(input code_t held, input code_t trial);
		return held >= trial;
	endfunction

	always_comb begin
		d = q;
		if (track) begin
			d.held   = sample;
			d.approx = CODE_ZERO;
			d.mask   = TRIAL_MSB;
		end else if (decide) begin
			if (trial_ge(q.held, q.approx | q.mask)) begin
				d.approx = q.approx | q.mask;
			end
			d.mask = q.mask >> 1;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			q <= '{held: CODE_ZERO, approx: CODE_ZERO, mask: TRIAL_MSB};
		end else begin
			q <= d;
		end
	end

	assign decided_bit = trial_ge(q.held, q.approx | q.mask);
	assign held_code   = q.held;
	assign result      = q.approx;
endmodule
`default_nettype wire

// File: adc_frame.sv
// Serial conversion frame sequencer of a 12-bit converter, clocked by sys_clk and paced by synchronised link clock falls
`timescale 1ns/1ns
`default_nettype none
module adc_frame
	import adc_frame_pkg::*;
(
	input  wire logic                         sys_clk,           // System clock, 100 MHz
	input  wire logic                         resetn,            // Async reset, active low
	input  wire adc_frame_pkg::link_in_t      link_in,           // Chip select and serial clock pins
	input  wire adc_frame_pkg::code_t         analog_input,      // Digitised input level
	output adc_frame_pkg::serial_pin_t        serial_result_out, // Data pin value and enable
	output adc_frame_pkg::code_t              result_code,       // Last completed result
	output logic                              result_valid,      // Pulse: result_code updated
	output logic                              result_untrusted,  // Result is first since reset
	output adc_frame_pkg::frame_status_t      frame_status       // Current frame phase
);
	link_in_t    link_s;
	code_t       sample_s;
	frame_regs_t q;
	frame_regs_t d;
	logic        cs_low;
	logic        sclk_fall;
	edge_cnt_t   next_edge;
	logic        sar_track;
	logic        sar_decide;
	logic        dec_bit;
	code_t       held_code;
	code_t       sar_result;

	pin_sync #(
		.W   (2),
		.RST ({CS_IDLE, SCLK_IDLE})
	) u_link_sync (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.async_in (link_in),
		.sync_out (link_s)
	);

	// Input level is taken as quiet around the hold edge, so per-bit sync suffices
	pin_sync #(
		.W   (RESULT_W),
		.RST (CODE_ZERO)
	) u_input_sync (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.async_in (analog_input),
		.sync_out (sample_s)
	);

	assign cs_low    = !link_s.cs_n;
	assign sclk_fall = q.sclk_prev && !link_s.sclk;
	assign next_edge = q.edges + EDGE_ONE;

	// Sample follows the input until the hold edge
	assign sar_track  = (q.st == ST_TRACK) || (q.st == ST_SHUTDOWN);
	// One bit resolved per falling edge from edge four to fifteen
	assign sar_decide = (q.st == ST_CONVERT) && sclk_fall && cs_low
		&& (next_edge >= FIRST_RESULT_EDGE)
		&& (next_edge <= LAST_RESULT_EDGE);

	sar_engine u_sar (
		.sys_clk     (sys_clk),
		.resetn      (resetn),
		.track       (sar_track),
		.decide      (sar_decide),
		.sample      (sample_s),
		.decided_bit (dec_bit),
		.held_code   (held_code),
		.result      (sar_result)
	);

	always_comb begin
		d            = q;
		d.sclk_prev  = link_s.sclk;
		d.code_valid = 1'h0;
		if (!cs_low) begin
			// Shutdown: pin released, any partial frame dropped
			d.st       = ST_SHUTDOWN;
			d.edges    = EDGE_NONE;
			d.pin.oe   = 1'h0;
			d.pin.data = LEAD_BIT;
		end else begin
			unique case (q.st)
				ST_SHUTDOWN: begin
					// Frame opens: drive the first leading zero
					d.st       = ST_TRACK;
					d.edges    = EDGE_NONE;
					d.pin.oe   = 1'h1;
					d.pin.data = LEAD_BIT;
				end
				ST_TRACK: begin
					if (sclk_fall) begin
						d.edges    = next_edge;
						d.pin.data = LEAD_BIT;
						if (next_edge == HOLD_EDGE) begin
							d.st = ST_CONVERT;
						end
					end
				end
				ST_CONVERT: begin
					if (sclk_fall) begin
						d.edges = next_edge;
						if (next_edge == LAST_EDGE) begin
							d.st         = ST_DONE;
							d.pin.oe     = 1'h0;
							d.pin.data   = LEAD_BIT;
							d.code       = sar_result;
							d.code_valid = 1'h1;
							d.untrusted  = !q.first_seen;
							d.first_seen = 1'h1;
						end else if (next_edge >= FIRST_RESULT_EDGE) begin
							// MSB first, launched on the falling edge
							d.pin.data = dec_bit;
						end else begin
							d.pin.data = LEAD_BIT;
						end
					end
				end
				ST_DONE: begin
					// Extra clocks after the sixteenth are ignored
					d.pin.oe = 1'h0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			q <= FRAME_REGS_RST;
		end else begin
			q <= d;
		end
	end

	assign serial_result_out       = q.pin;
	assign result_code             = q.code;
	assign result_valid            = q.code_valid;
	assign result_untrusted        = q.untrusted;
	assign frame_status.shutdown   = (q.st == ST_SHUTDOWN);
	assign frame_status.tracking   = (q.st == ST_TRACK);
	assign frame_status.converting = (q.st == ST_CONVERT);

	// Pin released one cycle after chip select is seen high
	shut_hiz_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		!cs_low |=> !serial_result_out.oe && (q.st == ST_SHUTDOWN)
	) else $error("data pin driven while chip select high");

	// Chip select fall opens a frame and drives the pin next cycle
	frame_open_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		cs_low && (q.st == ST_SHUTDOWN)
		|=> serial_result_out.oe && (q.st == ST_TRACK) && (q.edges == EDGE_NONE)
	) else $error("frame did not open on chip select fall");

	// Tracking ends exactly at the third falling edge
	hold_third_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		cs_low && (q.st == ST_TRACK) && sclk_fall && (next_edge == HOLD_EDGE)
		|=> (q.st == ST_CONVERT) && (q.edges == HOLD_EDGE)
	) else $error("hold not entered at third falling edge");

	// Held sample stays put through the whole conversion
	held_stable_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		(q.st == ST_CONVERT) && cs_low |=> $stable(held_code)
	) else $error("held sample changed during conversion");

	// Sixteenth falling edge releases the pin and posts the result
	last_edge_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		cs_low && (q.st == ST_CONVERT) && sclk_fall && (next_edge == LAST_EDGE)
		|=> !serial_result_out.oe && result_valid && (q.st == ST_DONE)
	) else $error("pin not released at sixteenth falling edge");

	// First four bits on the pin are zeros
	lead_zeros_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		serial_result_out.oe && (q.edges < FIRST_RESULT_EDGE)
		|-> serial_result_out.data == LEAD_BIT
	) else $error("leading bit not zero");

	// Ideal converter: finished code equals the held sample
	code_exact_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		result_valid |-> (result_code == held_code)
	) else $error("result code differs from held sample");

	// Result bit on the pin is the one resolved from this frame's sample
	bit_source_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		sar_decide |=> serial_result_out.data == $past(dec_bit)
			&& serial_result_out.oe
	) else $error("pin bit not from current conversion");

	// Serial clock ignored while chip select is high
	cs_gate_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		!cs_low && sclk_fall |=> (q.edges == EDGE_NONE) && !result_valid
	) else $error("serial clock counted while deselected");

	// Without a falling edge the frame does not advance
	clock_paced_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		cs_low && !sclk_fall && (q.st != ST_SHUTDOWN)
		|=> $stable(q.edges) && $stable(q.st)
	) else $error("frame advanced without a serial clock edge");

	// Data pin only changes on falling edges inside a frame
	fall_launch_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		cs_low && !sclk_fall && (q.st != ST_SHUTDOWN)
		|=> $stable(serial_result_out.data)
	) else $error("data changed off a falling edge");

	// A shutdown then reselect gives a full frame again
	reselect_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		(q.st == ST_SHUTDOWN) ##1 (q.st == ST_TRACK)
		|-> (q.edges == EDGE_NONE) && serial_result_out.oe
	) else $error("frame after shutdown did not restart cleanly");

	// Deselect also suppresses any result pulse
	shut_quiet_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		!cs_low |=> !result_valid && frame_status.shutdown
	) else $error("result posted while chip select high");

	// Sample follows the input right up to the hold edge
	track_follow_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		cs_low && (q.st == ST_TRACK) |=> held_code == $past(sample_s)
	) else $error("sample not following input while tracking");

	// Third fall takes the last tracked level, not a later one
	hold_take_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		cs_low && (q.st == ST_TRACK) && sclk_fall && (next_edge == HOLD_EDGE)
		|=> held_code == $past(sample_s)
	) else $error("sample not taken at the third falling edge");

	// No pin drive once the frame is done
	done_release_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		(q.st == ST_DONE) |-> !serial_result_out.oe
	) else $error("data pin driven after the sixteenth falling edge");

	// Falls past the sixteenth change nothing
	done_hold_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		cs_low && (q.st == ST_DONE)
		|=> (q.st == ST_DONE) && $stable(q.edges) && !result_valid
	) else $error("frame advanced after the sixteenth falling edge");

	// Pin is driven for the whole live frame
	frame_drive_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		((q.st == ST_TRACK) || (q.st == ST_CONVERT)) |-> serial_result_out.oe
	) else $error("data pin released inside a live frame");

	// First result bit is the top bit of the held sample
	msb_first_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		sar_decide && (next_edge == FIRST_RESULT_EDGE)
		|=> serial_result_out.data == held_code[RESULT_W-1]
	) else $error("first result bit is not the top bit");

	// Result pulse lasts exactly one cycle
	valid_pulse_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		result_valid |=> !result_valid
	) else $error("result pulse longer than one cycle");

	// Posted code only moves together with its pulse
	code_hold_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		!result_valid |-> $stable(result_code)
	) else $error("result code changed without a pulse");

	// Edge count only runs while selected
	idle_count_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		(q.st == ST_SHUTDOWN) |-> (q.edges == EDGE_NONE)
	) else $error("edge count nonzero in shutdown");

	// Count never passes the last edge of a frame
	count_bound_a: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		q.edges <= LAST_EDGE
	) else $error("edge count beyond the last falling edge");

endmodule
`default_nettype wire

// File: host_model.sv
// Host serial master model: chip select, link clock, bit capture
`timescale 1ns/1ns
`default_nettype none
module host_model
	import adc_frame_pkg::*;
(
	input  wire logic                       sys_clk, // Clock for the line keeper
	input  wire adc_frame_pkg::serial_pin_t pin,     // Device data pin and enable
	output logic                            cs_n,    // Chip select, active low
	output logic                            sclk     // Link clock, 80 ns period
);
	logic last_q;
	logic line;
	// Released line shows the inverse of the last bit, never a stale copy
	always @(posedge sys_clk) begin
		if (pin.oe) begin
			last_q <= pin.data;
		end
	end
	assign line = pin.oe ? pin.data : ~last_q;
	initial begin
		cs_n = 1'h1;
		sclk = 1'h0;
		last_q = 1'h0;
	end
	task automatic frame(input int nf, output logic [15:0] bits, output int miss,
			output logic late, output logic shut);
		bits = 16'h0000;
		miss = 0;
		// Launch 1 ns after a system edge, like every other bench input
		@(posedge sys_clk);
		#1;
		cs_n = 1'h0;
		#60;
		for (int k = 0; k < nf; k++) begin
			sclk = 1'h1;
			#40;
			// Capture late in the high phase, well after the falling-edge update
			if (k < 16) begin
				bits[15-k] = line;
				if (pin.oe !== 1'h1) miss++;
			end
			sclk = 1'h0;
			#40;
		end
		#60;
		late = pin.oe;
		cs_n = 1'h1;
		#60;
		shut = pin.oe;
	endtask
	task automatic idle_clocks(input int n);
		repeat (n) begin
			sclk = 1'h1;
			#40;
			sclk = 1'h0;
			#40;
		end
	endtask
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench for the serial converter frame sequencer
`timescale 1ns/1ns
`default_nettype none
module tb;
	import adc_frame_pkg::*;
	logic          sys_clk;
	logic          resetn;
	logic          cs_n;
	logic          sclk;
	link_in_t      link_in;
	code_t         analog_input;
	serial_pin_t   pin;
	code_t         result_code;
	logic          result_valid;
	logic          result_untrusted;
	frame_status_t frame_status;
	int            error_cnt;
	int            cmp_count;
	int            vcnt;
	int            nfull;
	logic [31:0]   rng;
	code_t         last_code;
	code_t         corners [4] = '{12'h000, 12'h800, 12'h7FF, 12'hFFF};
	assign link_in = '{cs_n: cs_n, sclk: sclk};
	adc_frame u_dut (
		.sys_clk(sys_clk), .resetn(resetn), .link_in(link_in),
		.analog_input(analog_input), .serial_result_out(pin),
		.result_code(result_code), .result_valid(result_valid),
		.result_untrusted(result_untrusted), .frame_status(frame_status)
	);
	host_model u_host (.sys_clk(sys_clk), .pin(pin), .cs_n(cs_n), .sclk(sclk));
	initial begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) if (result_valid === 1'h1) vcnt++;
	function automatic logic [15:0] expect_bits(input code_t c);
		return {4'h0, c};
	endfunction
	function automatic code_t next_code();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng[11:0];
	endfunction
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic drive_analog(input code_t v);
		@(posedge sys_clk);
		#1;
		analog_input = v;
	endtask
	task automatic complete_run();
		$display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic run_frame(input code_t code, input int nf);
		logic [15:0] bits;
		logic [15:0] exp;
		logic        late;
		logic        shut;
		int          miss;
		exp = expect_bits(code);
		drive_analog(~code);
		vcnt = 0;
		// Input moves to the real code while tracking, to junk once held
		fork
			u_host.frame(nf, bits, miss, late, shut);
			begin
				#100;
				drive_analog(code);
				chk("tracking", 16'h1, frame_status.tracking);
				if (nf >= 4) begin
					#260;
					drive_analog(~code);
					chk("converting", 16'h1, frame_status.converting);
				end
			end
		join
		if (nf >= 16) begin
			nfull++;
			last_code = code;
			chk("data bits", exp, bits);
			chk("release at last fall", 16'h0, late);
			chk("valid pulses", 16'h1, vcnt[15:0]);
		end else begin
			chk("partial bits", 16'h0, (bits ^ exp) >> (16 - nf));
			chk("driving before abort", 16'h1, late);
			chk("abort pulses", 16'h0, vcnt[15:0]);
		end
		chk("result code", {4'h0, last_code}, {4'h0, result_code});
		chk("pin enable in frame", 16'h0, miss[15:0]);
		chk("shutdown release", 16'h0, shut);
		chk("shutdown state", 16'h1, frame_status.shutdown);
		chk("untrusted", {15'h0, nfull <= 1}, result_untrusted);
	endtask
	initial begin
		resetn = 1'h0;
		analog_input = 12'h000;
		error_cnt = 0;
		cmp_count = 0;
		vcnt = 0;
		nfull = 0;
		last_code = 12'h000;
		rng = 32'h0000B3A9;
		repeat (6) @(posedge sys_clk);
		#1;
		resetn = 1'h1;
		repeat (4) @(posedge sys_clk);
		run_frame(12'h5A5, 0);
		foreach (corners[i]) run_frame(corners[i], 16);
		vcnt = 0;
		u_host.idle_clocks(20);
		chk("idle pulses", 16'h0, vcnt[15:0]);
		chk("idle pin", 16'h0, pin.oe);
		run_frame(next_code(), 8);
		run_frame(next_code(), 16);
		// Extra falls past the last one must be ignored
		for (int i = 0; i < 12; i++) run_frame(next_code(), (i % 3 == 0) ? 18 : 16);
		@(posedge sys_clk);
		#1;
		resetn = 1'h0;
		repeat (3) @(posedge sys_clk);
		chk("reset pin", 16'h0, pin.oe);
		chk("reset untrusted", 16'h1, result_untrusted);
		#1;
		resetn = 1'h1;
		nfull = 0;
		repeat (4) @(posedge sys_clk);
		run_frame(next_code(), 16);
		complete_run();
	end
	initial begin
		#200000;
		error_cnt++;
		$display("CHECK FAILED watchdog expected finish seen timeout");
		complete_run();
	end
endmodule
`default_nettype wire
